// ---- timer_core.sv ----
// standard and periodic 10-bit timers with apb registers
//
// Notes on behaviour
// R01: two timers, standard and periodic, each with a 10-bit counter.
// R02: comparator match raises interrupt, may clear counter and change output.
// R03: three-bit clock select picks sys, high, time-base or external clock.
// R04: external clock pin counts on software-chosen rising or falling edge.
// R05: capture pin triggers on rising, falling or both edges per function field.
// R06: each timer has separate comparator A and comparator P interrupts.
// R07: compare match output mode drives output high, low or toggles.
// R08: pwm waveform appears on the primary output pin.
// R09: output reaches pin only when its pin-share bit selects the timer.
// R10: counter, compare A, period split into bytes; low via holding buffer.
// R11: low-byte write goes only into holding buffer.
// R12: high-byte write also copies holding buffer into low byte.
// R13: high-byte read also copies low byte into holding buffer.
// R14: low-byte read returns holding buffer.
// R15: software writes low then high, reads high then low.
// R16: standard timer has compare, counter, capture, single pulse, pwm modes.
// R17: standard timer has clock and capture inputs, output and inverted output.
// R18: mode field 00 compare, 01 capture, 10 pwm/single pulse, 11 counter.
// R19: standard comparator P is 3 bits against counter top bits, periodic uses all 10; zero means 1024.
// R20: rising on-bit clears counter; software cannot write counter otherwise.
// R21: clock codes 110 and 111 use external pin rising and falling edge.
// R22: external clock and capture pins synchronised then edge-detected.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module timer_core (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic internal_high_tick_i,
  input wire logic time_base_tick_i,
  input wire logic std_ext_clock_pin_i,
  input wire logic std_capture_pin_i,
  input wire logic per_ext_clock_pin_i,
  input wire logic per_capture_pin_i,
  input wire logic alt_std_output_i,
  input wire logic alt_std_inverted_i,
  input wire logic alt_per_output_i,
  input wire logic alt_per_inverted_i,
  output logic std_output_pin_o,
  output logic std_output_inverted_pin_o,
  output logic per_output_pin_o,
  output logic per_output_inverted_pin_o,
  output logic [1:0] irq_a_o,
  output logic [1:0] irq_p_o
);
  import timer_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [9:0] cnt;
    logic [9:0] cmpa;
    logic [9:0] per;
    logic [7:0] hold;
    logic on_d;
    logic out;
    logic irq_a;
    logic irq_p;
    logic [2:0] ck_s;
    logic [2:0] cp_s;
    logic ck_l;
    logic cp_l;
  } tm_t;

  typedef struct packed {
    tm_t [1:0] tm;
    logic [1:0] psc;
    logic [5:0] fh_cnt;
    logic [3:0] pinsel;
    logic [3:0] pins;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic [1:0] a_hit_w;
  logic [1:0] p_hit_w;
  logic [1:0] cap_w;
  logic [1:0] on_rise_w;

  // {fall, rise} once the second and third sync stages agree
  function automatic logic [1:0] edges(input logic [2:0] sy, input logic lvl);
    logic agree;
    agree = sy[1] == sy[2];
    edges = {agree & !sy[2] & lvl, agree & sy[2] & !lvl};
  endfunction

  // period compare: standard uses top three bits, periodic all ten
  function automatic logic p_match(input logic full, input logic [2:0] compare_p_value,
                                   input logic [9:0] per, input logic [10:0] inc);
    logic hit;
    hit = 1'b0;
    if (full) begin
      hit = (per == 10'h000) ? (inc == FULL_COUNT) : (inc == {1'b0, per});
    end else begin
      hit = (compare_p_value == 3'h0) ? (inc == FULL_COUNT) :
            (inc == {1'b0, compare_p_value, 7'h00});
    end
    p_match = hit;
  endfunction

  always_comb begin
    logic acc;
    logic done;
    logic rd_cap;
    logic tm_sel;
    logic ps_sel;
    logic mapped;
    logic tmi;
    logic [2:0] slot;
    logic [31:0] rd_val;
    logic fsys4;
    logic fh16;
    logic fh64;
    logic tick;
    logic run;
    logic on_rise;
    logic a_hit;
    logic p_hit;
    logic per_hit;
    logic duty_hit;
    logic clr;
    logic cap_ev;
    logic [1:0] ck_e;
    logic [1:0] cp_e;
    logic [10:0] inc;
    logic [1:0] func;
    logic [1:0] ext_ck;
    logic [1:0] ext_cp;
    logic [1:0] lvl;
    acc = 1'b0;
    done = 1'b0;
    rd_cap = 1'b0;
    tm_sel = 1'b0;
    ps_sel = 1'b0;
    mapped = 1'b0;
    tmi = 1'b0;
    slot = 3'h0;
    rd_val = 32'h0000_0000;
    fsys4 = 1'b0;
    fh16 = 1'b0;
    fh64 = 1'b0;
    tick = 1'b0;
    run = 1'b0;
    on_rise = 1'b0;
    a_hit = 1'b0;
    p_hit = 1'b0;
    per_hit = 1'b0;
    duty_hit = 1'b0;
    clr = 1'b0;
    cap_ev = 1'b0;
    ck_e = 2'b00;
    cp_e = 2'b00;
    inc = 11'h000;
    func = 2'b00;
    ext_ck = {per_ext_clock_pin_i, std_ext_clock_pin_i};
    ext_cp = {per_capture_pin_i, std_capture_pin_i};
    lvl = 2'b00;
    a_hit_w = 2'b00;
    p_hit_w = 2'b00;
    cap_w = 2'b00;
    on_rise_w = 2'b00;
    s_nxt = s_r;

    // shared prescalers, one-cycle enables
    s_nxt.psc = s_r.psc + 2'h1;
    fsys4 = s_r.psc == SYSTEM_CLOCK_FREQ_DIV4_LAST;
    if (internal_high_tick_i) begin
      s_nxt.fh_cnt = s_r.fh_cnt + 6'h01;
    end
    fh16 = internal_high_tick_i & (s_r.fh_cnt[3:0] == FH_DIV16_LAST);
    fh64 = internal_high_tick_i & (s_r.fh_cnt == FH_DIV64_LAST);

    // apb: one wait state so read data leaves a flip-flop
    acc = psel_i & penable_i;
    done = acc & s_r.pready;
    rd_cap = acc & !s_r.pready & !pwrite_i;
    tm_sel = (paddr_i[7:6] == 2'b00) & (paddr_i[1:0] == 2'b00);
    ps_sel = paddr_i == PINSEL_ADDR;
    tmi = paddr_i[PER_SEL_BIT];
    slot = paddr_i[4:2];
    // standard timer has no period byte pair
    mapped = ps_sel | (tm_sel & (tmi | (slot < REG_PER_LO)));
    s_nxt.pready = acc & !s_r.pready;

    for (int i = 0; i < 2; i++) begin
      s_nxt.tm[i].irq_a = 1'b0;
      s_nxt.tm[i].irq_p = 1'b0;
      // three-stage sync; stage 0 feeds only stage 1
      s_nxt.tm[i].ck_s = {s_r.tm[i].ck_s[1:0], ext_ck[i]}; // R22
      s_nxt.tm[i].cp_s = {s_r.tm[i].cp_s[1:0], ext_cp[i]}; // R22
      if (s_r.tm[i].ck_s[1] == s_r.tm[i].ck_s[2]) begin
        s_nxt.tm[i].ck_l = s_r.tm[i].ck_s[2];
      end
      if (s_r.tm[i].cp_s[1] == s_r.tm[i].cp_s[2]) begin
        s_nxt.tm[i].cp_l = s_r.tm[i].cp_s[2];
      end
      ck_e = edges(s_r.tm[i].ck_s, s_r.tm[i].ck_l); // R22
      cp_e = edges(s_r.tm[i].cp_s, s_r.tm[i].cp_l); // R22

      case (clk_sel_t'(s_r.tm[i].ctrl0[C0_CLK_LO +: 3])) // R03
        CLK_SYS4: tick = fsys4;
        CLK_SYS: tick = 1'b1;
        CLK_H16: tick = fh16;
        CLK_H64: tick = fh64;
        CLK_TB0, CLK_TB1: tick = time_base_tick_i;
        CLK_EXT_RISE: tick = ck_e[0]; // R04 R21
        CLK_EXT_FALL: tick = ck_e[1]; // R04 R21
        default: tick = 1'b0;
      endcase

      s_nxt.tm[i].on_d = s_r.tm[i].ctrl0[C0_ON];
      on_rise = s_r.tm[i].ctrl0[C0_ON] & !s_r.tm[i].on_d;
      run = s_r.tm[i].ctrl0[C0_ON] & !s_r.tm[i].ctrl0[C0_PAUSE] & tick;
      inc = {1'b0, s_r.tm[i].cnt} + 11'h001;
      func = s_r.tm[i].ctrl1[C1_FUNC_LO +: 2];
      // capture mode keeps comparator A for the captured value
      a_hit = run & (inc == {1'b0, s_r.tm[i].cmpa})
              & (s_r.tm[i].ctrl1[C1_MODE_LO +: 2] != MODE_CAP); // R02
      p_hit = run & p_match(i == 1, s_r.tm[i].ctrl0[C0_COMPARE_P_VALUE_LO +: 3],
                            s_r.tm[i].per, inc); // R19
      per_hit = s_r.tm[i].ctrl1[C1_DPX] ? a_hit : p_hit;
      duty_hit = s_r.tm[i].ctrl1[C1_DPX] ? p_hit : a_hit;

      case (mode_t'(s_r.tm[i].ctrl1[C1_MODE_LO +: 2])) // R16 R18
        MODE_CMP: begin
          clr = s_r.tm[i].ctrl1[C1_CCLR] ? a_hit : p_hit; // R02
          if (on_rise) begin
            s_nxt.tm[i].out = s_r.tm[i].ctrl1[C1_INIT];
          end else if (a_hit) begin
            case (func) // R07
              2'b01: s_nxt.tm[i].out = 1'b0;
              2'b10: s_nxt.tm[i].out = 1'b1;
              2'b11: s_nxt.tm[i].out = !s_r.tm[i].out;
              default: s_nxt.tm[i].out = s_r.tm[i].out;
            endcase
          end
        end
        MODE_PWM: begin
          clr = per_hit;
          case (func)
            2'b00: s_nxt.tm[i].out = 1'b0;
            2'b01: s_nxt.tm[i].out = 1'b1;
            2'b10: begin
              // period edge wins when both land together
              if (on_rise || per_hit) begin
                s_nxt.tm[i].out = 1'b1; // R08
              end else if (duty_hit) begin
                s_nxt.tm[i].out = 1'b0; // R08
              end
            end
            default: begin
              if (on_rise) begin
                s_nxt.tm[i].out = 1'b1;
              end else if (a_hit) begin
                s_nxt.tm[i].out = 1'b0;
              end
            end
          endcase
        end
        MODE_CAP: begin
          clr = p_hit;
          case (func) // R05
            2'b00: cap_ev = cp_e[0];
            2'b01: cap_ev = cp_e[1];
            2'b10: cap_ev = cp_e[0] | cp_e[1];
            default: cap_ev = 1'b0;
          endcase
          cap_ev = cap_ev & s_r.tm[i].ctrl0[C0_ON];
        end
        default: clr = s_r.tm[i].ctrl1[C1_CCLR] ? a_hit : p_hit;
      endcase

      if (on_rise) begin
        s_nxt.tm[i].cnt = 10'h000; // R20
      end else if (run) begin
        s_nxt.tm[i].cnt = clr ? 10'h000 : inc[9:0]; // R01 R02
      end

      // register access for this timer
      if (done && pwrite_i && tm_sel && (tmi == i[0])) begin
        case (slot)
          REG_CTRL0: s_nxt.tm[i].ctrl0 = pwdata_i[7:0];
          REG_CTRL1: s_nxt.tm[i].ctrl1 = pwdata_i[7:0];
          REG_CMPA_LO, REG_PER_LO: s_nxt.tm[i].hold = pwdata_i[7:0]; // R11
          REG_CMPA_HI: s_nxt.tm[i].cmpa = {pwdata_i[1:0], s_r.tm[i].hold}; // R12
          REG_PER_HI: begin
            if (i == 1) begin
              s_nxt.tm[i].per = {pwdata_i[1:0], s_r.tm[i].hold}; // R12
            end
          end
          default: s_nxt.tm[i].cnt = s_nxt.tm[i].cnt; // R20
        endcase
      end
      if (rd_cap && tm_sel && (tmi == i[0])) begin
        case (slot)
          REG_CNT_HI: s_nxt.tm[i].hold = s_r.tm[i].cnt[7:0]; // R13
          REG_CMPA_HI: s_nxt.tm[i].hold = s_r.tm[i].cmpa[7:0]; // R13
          REG_PER_HI: s_nxt.tm[i].hold = s_r.tm[i].per[7:0]; // R13
          default: s_nxt.tm[i].hold = s_nxt.tm[i].hold;
        endcase
      end
      // capture overrides a coincident software write
      if (cap_ev) begin
        s_nxt.tm[i].cmpa = s_r.tm[i].cnt; // R05
      end

      s_nxt.tm[i].irq_a = a_hit | cap_ev; // R06
      s_nxt.tm[i].irq_p = p_hit; // R06
      a_hit_w[i] = a_hit;
      p_hit_w[i] = p_hit;
      cap_w[i] = cap_ev;
      on_rise_w[i] = on_rise;
      lvl[i] = s_r.tm[i].out ^ s_r.tm[i].ctrl1[C1_POL];
    end

    if (done && pwrite_i && ps_sel) begin
      s_nxt.pinsel = pwdata_i[3:0];
    end
    // hi-byte reads return the live high bits, lo-byte reads the buffer
    if (ps_sel) begin
      rd_val = {28'h0000000, s_r.pinsel};
    end else begin
      case (slot)
        REG_CTRL0: rd_val = {24'h000000, s_r.tm[tmi].ctrl0};
        REG_CTRL1: rd_val = {24'h000000, s_r.tm[tmi].ctrl1};
        REG_CNT_HI: rd_val = {30'h00000000, s_r.tm[tmi].cnt[9:8]}; // R10
        REG_CMPA_HI: rd_val = {30'h00000000, s_r.tm[tmi].cmpa[9:8]}; // R10
        REG_PER_HI: rd_val = {30'h00000000, s_r.tm[tmi].per[9:8]}; // R10
        default: rd_val = {24'h000000, s_r.tm[tmi].hold}; // R14
      endcase
    end
    if (rd_cap) begin
      s_nxt.prdata = mapped ? rd_val : 32'h0000_0000;
    end
    if (acc && !s_r.pready) begin
      s_nxt.pslverr = !mapped;
    end

    // other pin function kept unless the select bit hands it over
    s_nxt.pins[PS_STD_OUT] = s_r.pinsel[PS_STD_OUT] ? lvl[0] : alt_std_output_i; // R09
    s_nxt.pins[PS_STD_INV] = s_r.pinsel[PS_STD_INV] ? !lvl[0] : alt_std_inverted_i; // R09 R17
    s_nxt.pins[PS_PER_OUT] = s_r.pinsel[PS_PER_OUT] ? lvl[1] : alt_per_output_i; // R09
    s_nxt.pins[PS_PER_INV] = s_r.pinsel[PS_PER_INV] ? !lvl[1] : alt_per_inverted_i; // R09
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.tm[0].ctrl0 <= CTRL_RST;
      s_r.tm[0].ctrl1 <= CTRL_RST;
      s_r.tm[1].ctrl0 <= CTRL_RST;
      s_r.tm[1].ctrl1 <= CTRL_RST;
      s_r.pinsel <= PINSEL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o = s_r.prdata;
  assign pready_o = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign std_output_pin_o = s_r.pins[PS_STD_OUT];
  assign std_output_inverted_pin_o = s_r.pins[PS_STD_INV];
  assign per_output_pin_o = s_r.pins[PS_PER_OUT];
  assign per_output_inverted_pin_o = s_r.pins[PS_PER_INV];
  assign irq_a_o = {s_r.tm[1].irq_a, s_r.tm[0].irq_a};
  assign irq_p_o = {s_r.tm[1].irq_p, s_r.tm[0].irq_p};

  // checks on the standard timer's byte access and timing, and on the periodic timer's compare A pulse
  localparam logic [7:0] A_CNT_HI = {3'b000, REG_CNT_HI, 2'b00};
  localparam logic [7:0] A_CNT_LO = {3'b000, REG_CNT_LO, 2'b00};
  localparam logic [7:0] A_CMPA_LO = {3'b000, REG_CMPA_LO, 2'b00};
  localparam logic [7:0] A_CMPA_HI = {3'b000, REG_CMPA_HI, 2'b00};
  logic acc_w;
  logic wr_alo;
  logic wr_ahi;
  logic rd_chi;
  logic rd_clo;
  assign acc_w = psel_i & penable_i;
  assign wr_alo = acc_w & pready_o & pwrite_i & (paddr_i == A_CMPA_LO);
  assign wr_ahi = acc_w & pready_o & pwrite_i & (paddr_i == A_CMPA_HI);
  assign rd_chi = acc_w & !pready_o & !pwrite_i & (paddr_i == A_CNT_HI);
  assign rd_clo = acc_w & pready_o & !pwrite_i & (paddr_i == A_CNT_LO);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_on_clear: assert property (on_rise_w[0] |=> s_r.tm[0].cnt == 10'h000) // R20
    else $error("counter not cleared on timer start");
  chk_lo_write_buf: assert property (wr_alo && !cap_w[0] |=> // R11
      s_r.tm[0].hold == $past(pwdata_i[7:0]) && $stable(s_r.tm[0].cmpa))
    else $error("low byte write did not stay in buffer");
  chk_hi_write_copy: assert property (wr_ahi && !cap_w[0] |=> // R12
      s_r.tm[0].cmpa == {$past(pwdata_i[1:0]), $past(s_r.tm[0].hold)})
    else $error("high byte write did not merge buffer");
  chk_hi_read_latch: assert property (rd_chi |=> // R13
      s_r.tm[0].hold == $past(s_r.tm[0].cnt[7:0]) && pready_o)
    else $error("high byte read did not latch low byte");
  chk_lo_read_buf: assert property (rd_clo |-> prdata_o[7:0] == s_r.tm[0].hold) // R14
    else $error("low byte read not from buffer");
  chk_irq_a_pulse: assert property (a_hit_w[1] |=> irq_a_o[1] ##1 // R06
      (!irq_a_o[1] || $past(a_hit_w[1] | cap_w[1])))
    else $error("compare A interrupt pulse wrong");
  chk_pin_share: assert property (!s_r.pinsel[PS_STD_OUT] |=> // R09
      std_output_pin_o == $past(alt_std_output_i))
    else $error("timer output leaked onto shared pin");
  chk_cap_store: assert property (cap_w[0] |=> // R05
      s_r.tm[0].cmpa == $past(s_r.tm[0].cnt) && irq_a_o[0])
    else $error("capture did not store counter");
  chk_out_init: assert property (on_rise_w[0] && // R07
      s_r.tm[0].ctrl1[C1_MODE_LO +: 2] == MODE_CMP |=>
      s_r.tm[0].out == $past(s_r.tm[0].ctrl1[C1_INIT]))
    else $error("output not reset to initial level");

  cov_cmp_a: cover property (a_hit_w[0] ##1 irq_a_o[0]);
  cov_period: cover property (p_hit_w[1] ##1 irq_p_o[1]);
  cov_capture: cover property (cap_w[0]);
  cov_byte_read: cover property (rd_chi ##[1:8] rd_clo);
endmodule

// ---- timer_module_common_core_tb.sv ----
// self-checking testbench for the dual 10-bit timer block
`timescale 1ns/1ps
module timer_module_common_core_tb;
  import timer_pkg::*;
  logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic hi_tick, base_tick, x_clk, x_cap, e, p1;
  logic [3:0] alt;
  logic s_out, s_inv, p_out, p_inv;
  logic [1:0] irq_a, irq_p;
  int n_fail = 0;
  int total_checks = 0;
  int n;

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  timer_pins_model pm (.clk_i(clk_i), .ext_clk_o(x_clk), .cap_o(x_cap),
    .high_tick_o(hi_tick), .base_tick_o(base_tick));

  timer_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .internal_high_tick_i(hi_tick),
    .time_base_tick_i(base_tick), .std_ext_clock_pin_i(x_clk), .std_capture_pin_i(x_cap),
    .per_ext_clock_pin_i(x_clk), .per_capture_pin_i(x_cap), .alt_std_output_i(alt[0]),
    .alt_std_inverted_i(alt[1]), .alt_per_output_i(alt[2]), .alt_per_inverted_i(alt[3]),
    .std_output_pin_o(s_out), .std_output_inverted_pin_o(s_inv), .per_output_pin_o(p_out),
    .per_output_inverted_pin_o(p_inv), .irq_a_o(irq_a), .irq_p_o(irq_p));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      report_and_stop();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, q);
  endtask

  function automatic logic sig(input int s);
    return (s == 0) ? irq_a[0] : (s == 1) ? irq_p[0] : (s == 2) ? irq_p[1] : irq_a[1];
  endfunction

  // n ends as cycles up to and including the next pulse
  task automatic wp(input int s);
    int i;
    n = 0;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk_i);
      n++;
      if (sig(s) === 1'b1) break;
    end
    if (i == 3000) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  task automatic cnt(input int s, input int c);
    n = 0;
    repeat (c) begin
      @(posedge clk_i);
      if (sig(s) === 1'b1) n++;
    end
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  initial begin
    rst_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    alt = 4'h0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'h00, 32'h0, "ctrl0_reset");
    rd(8'h0C, 32'h0, "count_reset");
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", 32'h1, e);
    chk("unmapped_data", 32'h0, q);
    done("reset");
    alt <= 4'hF;
    repeat (3) @(posedge clk_i);
    chk("pins_alt_f", 32'hF, {p_inv, p_out, s_inv, s_out});
    alt <= 4'h5;
    repeat (3) @(posedge clk_i);
    chk("pins_alt_5", 32'h5, {p_inv, p_out, s_inv, s_out});
    done("pin_share");
    wr(8'h10, 32'h5A);
    rd(8'h14, 32'h0, "cmpa_hi");
    rd(8'h10, 32'h0, "cmpa_lo_unlatched");
    wr(8'h10, 32'h09);
    wr(8'h14, 32'h0);
    rd(8'h14, 32'h0, "cmpa_hi_b");
    rd(8'h10, 32'h9, "cmpa_lo");
    done("byte_access");
    wr(PINSEL_ADDR, 32'h1);
    wr(8'h04, 32'h31);
    wr(8'h00, 32'h18);
    wp(0);
    wp(0);
    chk("cmpa_period", 32'd9, n);
    repeat (2) @(posedge clk_i);
    p1 = s_out;
    wp(0);
    repeat (2) @(posedge clk_i);
    chk("toggle", p1, !s_out);
    done("compare_a");
    for (int c = 0; c < 2; c++) begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h18 | c);
      wp(1);
      wp(1);
      chk("period_p", (c == 0) ? 32'd1024 : 32'd128, n);
    end
    done("compare_p");
    // pwm: period 128 from compare_p_value 1, duty 32 from compare A
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h20);
    wr(8'h14, 32'h0);
    wr(8'h04, 32'hA0);
    wr(8'h00, 32'h19);
    repeat (4) @(posedge clk_i);
    n = 0;
    repeat (128) begin
      @(posedge clk_i);
      n += s_out;
    end
    chk("pwm_duty", 32'd32, n);
    done("pwm");
    // 0x105 = 261 cycles per period
    wr(8'h38, 32'h05);
    wr(8'h3C, 32'h01);
    rd(8'h3C, 32'h1, "per_hi");
    rd(8'h38, 32'h5, "per_lo");
    wr(8'h30, 32'h64);
    wr(8'h34, 32'h0);
    wr(8'h24, 32'h0);
    wr(8'h20, 32'h18);
    wp(2);
    wp(2);
    chk("periodic_gap", 32'd261, n);
    wp(3);
    wp(3);
    chk("periodic_a_gap", 32'd261, n);
    done("periodic");
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h68);
    pm.toggles(5);
    repeat (8) @(posedge clk_i);
    wr(8'h08, 32'hFF);
    wr(8'h0C, 32'h3);
    rd(8'h0C, 32'h0, "ext_rise_hi");
    rd(8'h08, 32'h3, "ext_rise_lo");
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h78);
    pm.toggles(3);
    repeat (8) @(posedge clk_i);
    rd(8'h0C, 32'h0, "ext_fall_hi");
    rd(8'h08, 32'h2, "ext_fall_lo");
    done("ext_clock");
    for (int f = 0; f < 3; f++) begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h40 | (f << 4));
      wr(8'h00, 32'h18);
      fork
        pm.cap_pulse(4);
        cnt(0, 40);
      join
      chk("capture_irq", (f == 2) ? 32'd2 : 32'd1, n);
    end
    done("capture");
    report_and_stop();
  end
endmodule

// ---- timer_pins_model.sv ----
// far-side model of the timer pins: external clock, capture input and tick sources
`timescale 1ns/1ps
module timer_pins_model (
  input wire logic clk_i,
  output logic ext_clk_o,
  output logic cap_o,
  output logic high_tick_o,
  output logic base_tick_o
);
  logic [3:0] div_r = 4'h0;

  initial begin
    ext_clk_o = 1'b0;
    cap_o = 1'b0;
  end

  always @(posedge clk_i) begin
    div_r <= div_r + 4'h1;
  end

  // tick enables run free, unlike the pin clock
  assign high_tick_o = (div_r[1:0] == 2'h3);
  assign base_tick_o = (div_r == 4'hF);

  // pin clock only moves inside a burst, slow enough for the synchroniser
  task automatic toggles(input int k);
    repeat (k) begin
      repeat (4) @(posedge clk_i);
      ext_clk_o <= !ext_clk_o;
    end
  endtask

  task automatic cap_pulse(input int h);
    repeat (h) @(posedge clk_i);
    cap_o <= 1'b1;
    repeat (h) @(posedge clk_i);
    cap_o <= 1'b0;
  endtask
endmodule

// ---- timer_pkg.sv ----
// constants and types shared by the dual timer block
package timer_pkg;
  localparam int unsigned CNT_W = 10;
  localparam logic [10:0] FULL_COUNT = 11'h400;
  // slot index within a timer window; byte address = 4 * slot
  localparam logic [2:0] REG_CTRL0 = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_CNT_LO = 3'h2;
  localparam logic [2:0] REG_CNT_HI = 3'h3;
  localparam logic [2:0] REG_CMPA_LO = 3'h4;
  localparam logic [2:0] REG_CMPA_HI = 3'h5;
  localparam logic [2:0] REG_PER_LO = 3'h6;
  localparam logic [2:0] REG_PER_HI = 3'h7;
  localparam int unsigned PER_SEL_BIT = 5;
  localparam logic [7:0] PINSEL_ADDR = 8'h40;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] PINSEL_RST = 4'h0;
  // control 0 fields
  localparam int unsigned C0_PAUSE = 7;
  localparam int unsigned C0_CLK_LO = 4;
  localparam int unsigned C0_ON = 3;
  localparam int unsigned C0_COMPARE_P_VALUE_LO = 0;
  // control 1 fields
  localparam int unsigned C1_MODE_LO = 6;
  localparam int unsigned C1_FUNC_LO = 4;
  localparam int unsigned C1_INIT = 3;
  localparam int unsigned C1_POL = 2;
  localparam int unsigned C1_DPX = 1;
  localparam int unsigned C1_CCLR = 0;
  // pin-share select bits
  localparam int unsigned PS_STD_OUT = 0;
  localparam int unsigned PS_STD_INV = 1;
  localparam int unsigned PS_PER_OUT = 2;
  localparam int unsigned PS_PER_INV = 3;
  // divider terminal counts
  localparam logic [1:0] SYSTEM_CLOCK_FREQ_DIV4_LAST = 2'h3;
  localparam logic [3:0] FH_DIV16_LAST = 4'hF;
  localparam logic [5:0] FH_DIV64_LAST = 6'h3F;
  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } mode_t;
  typedef enum logic [2:0] {
    CLK_SYS4 = 3'b000,
    CLK_SYS = 3'b001,
    CLK_H16 = 3'b010,
    CLK_H64 = 3'b011,
    CLK_TB0 = 3'b100,
    CLK_TB1 = 3'b101,
    CLK_EXT_RISE = 3'b110,
    CLK_EXT_FALL = 3'b111
  } clk_sel_t;
endpackage
